// ==== logic/plrtc_ctrl.sv ====
// Serial control decode for PLL counter reset and charge-pump tri-state
//
// Contract
// - Decode slip-reduction selector to sample factor
// - Prescale divides main lock-detect rate by four
// - Aux reset bit resets counters, tri-states pump
// - Main reset bit resets counters, tri-states pump
// - Power-up always applies a counter reset
// - Main tri-state bit floats pump, counters run
// - Aux tri-state bit floats pump, counters run
`timescale 1ns/100ps
module plrtc_ctrl
  import plrtc_pkg::*;
#(
  parameter int PWRUP_CYCLES = PWRUP_CYC
) (
  input  wire logic       i_clk,           // 40 MHz clock
  input  wire logic       i_rst,           // Async reset, high
  input  wire logic       i_ser_clk,       // Serial clock pin
  input  wire logic       i_ser_data,      // Serial data pin
  input  wire logic       i_ser_latch,     // Serial latch enable pin
  input  wire logic       i_chip_en,       // Chip enable pin
  input  wire logic       i_sw_pwr_up,     // Software power-up pulse
  input  wire logic       i_main_cmp,      // Main comparison clock
  input  wire logic       i_aux_cmp,       // Aux comparison clock
  output logic            o_slip_en,       // Slip reduction enabled
  output logic [2:0]      o_slip_shift,    // Factor is 1/2**shift
  output logic            o_main_cnt_rst,  // Main N/R counter reset
  output logic            o_aux_cnt_rst,   // Aux N/R counter reset
  output logic            o_main_cp_hiz,   // Main pump high-z
  output logic            o_aux_cp_hiz,    // Aux pump high-z
  output logic            o_main_ld_tick,  // Main lock-detect event
  output logic            o_aux_ld_tick    // Aux lock-detect event
);

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [2:0]        sck;
    logic [1:0]        sda;
    logic [2:0]        sle;
    logic [2:0]        sce;
    logic [2:0]        mcp;
    logic [2:0]        acp;
    logic [WORD_W-1:0] shift;
    logic [1:0]        slip_sel;
    logic [4:0]        ctl;
    logic [1:0]        div;
    logic [3:0]        por;
    logic              slip_en;
    logic [2:0]        slip_shift;
    logic              main_rst;
    logic              aux_rst;
    logic              main_hiz;
    logic              aux_hiz;
    logic              main_tick;
    logic              aux_tick;
  } plrtc_state_t;

  localparam logic [3:0] POR_LOAD = 4'(PWRUP_CYCLES);

  plrtc_state_t st_reg;
  plrtc_state_t st_next;
  logic         sck_rise;
  logic         le_rise;
  logic         pwr_up;
  logic         m_edge;
  logic         a_edge;

  assign sck_rise = st_reg.sck[1] & ~st_reg.sck[2];
  assign le_rise  = st_reg.sle[1] & ~st_reg.sle[2];
  assign pwr_up   = (st_reg.sce[1] & ~st_reg.sce[2]) | i_sw_pwr_up;
  assign m_edge   = st_reg.mcp[1] & ~st_reg.mcp[2];
  assign a_edge   = st_reg.acp[1] & ~st_reg.acp[2];

  function automatic logic [2:0] slip_decode(input logic [1:0] sel);
    case (sel)
      2'h0:    slip_decode = SHIFT_OFF;
      2'h1:    slip_decode = SHIFT_HALF;
      2'h2:    slip_decode = SHIFT_QUART;
      default: slip_decode = SHIFT_SIXT;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic por_busy;
    por_busy = 1'b0;
    st_next = st_reg;
    // Pin synchronisers, stage 0 feeds only stage 1
    st_next.sck = {st_reg.sck[1:0], i_ser_clk};
    st_next.sda = {st_reg.sda[0], i_ser_data};
    st_next.sle = {st_reg.sle[1:0], i_ser_latch};
    st_next.sce = {st_reg.sce[1:0], i_chip_en};
    st_next.mcp = {st_reg.mcp[1:0], i_main_cmp};
    st_next.acp = {st_reg.acp[1:0], i_aux_cmp};
    if (sck_rise) begin
      st_next.shift = {st_reg.shift[WORD_W-2:0], st_reg.sda[1]};
    end
    if (le_rise) begin
      if (st_reg.shift[ADDR_W-1:0] == ADDR_SLIP) begin
        st_next.slip_sel = st_reg.shift[SLIP_MSB:SLIP_LSB];
      end
      if (st_reg.shift[ADDR_W-1:0] == ADDR_CTRL) begin
        st_next.ctl = st_reg.shift[BIT_AUX_HIZ:BIT_PRESC];
      end
    end
    // Power-up counter reset window
    if (pwr_up) begin
      st_next.por = POR_LOAD;
    end else if (st_reg.por != 4'h0) begin
      st_next.por = st_reg.por - 4'h1;
    end
    por_busy = (st_reg.por != 4'h0) | pwr_up;
    st_next.slip_en    = (st_reg.slip_sel != 2'h0);
    st_next.slip_shift = slip_decode(st_reg.slip_sel);
    st_next.main_rst  = st_reg.ctl[2] | por_busy;
    st_next.aux_rst   = st_reg.ctl[1] | por_busy;
    st_next.main_hiz  = st_reg.ctl[2] | st_reg.ctl[3];
    st_next.aux_hiz   = st_reg.ctl[1] | st_reg.ctl[4];
    // Lock-detect rate: main may be divided, aux never
    st_next.main_tick = 1'b0;
    if (m_edge) begin
      st_next.div = st_reg.div + 2'h1;
      st_next.main_tick = ~st_reg.ctl[0] | (st_reg.div == LD_DIV_LAST);
    end
    st_next.aux_tick = a_edge;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg           <= '0;
      st_reg.slip_sel  <= SLIP_RST;
      st_reg.ctl       <= CTRL_RST;
      st_reg.por       <= POR_LOAD;
      st_reg.main_rst  <= 1'b1;
      st_reg.aux_rst   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_slip_en      = st_reg.slip_en;
  assign o_slip_shift   = st_reg.slip_shift;
  assign o_main_cnt_rst = st_reg.main_rst;
  assign o_aux_cnt_rst  = st_reg.aux_rst;
  assign o_main_cp_hiz  = st_reg.main_hiz;
  assign o_aux_cp_hiz   = st_reg.aux_hiz;
  assign o_main_ld_tick = st_reg.main_tick;
  assign o_aux_ld_tick  = st_reg.aux_tick;

  ////////////////////////////////////////////////////////////////////////
  slip_map_a: assert property (@(posedge i_clk) disable iff (i_rst)
    st_reg.slip_sel == 2'h3 |=> o_slip_en && o_slip_shift == SHIFT_SIXT)
    else $error("slip selector 3 not decoded to 1/16");

  slip_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
    st_reg.slip_sel == 2'h0 |=> !o_slip_en && o_slip_shift == SHIFT_OFF)
    else $error("slip selector 0 not disabled");

  slip_half_a: assert property (@(posedge i_clk) disable iff (i_rst)
    st_reg.slip_sel == 2'h1 |=> o_slip_en && o_slip_shift == SHIFT_HALF)
    else $error("slip selector 1 not decoded to 1/2");

  slip_quart_a: assert property (@(posedge i_clk) disable iff (i_rst)
    st_reg.slip_sel == 2'h2 |=> o_slip_en && o_slip_shift == SHIFT_QUART)
    else $error("slip selector 2 not decoded to 1/4");

  ld_prescale_a: assert property (@(posedge i_clk) disable iff (i_rst)
    m_edge && st_reg.ctl[0] && st_reg.div != LD_DIV_LAST
    |=> !o_main_ld_tick)
    else $error("main lock-detect tick not divided");

  aux_undiv_a: assert property (@(posedge i_clk) disable iff (i_rst)
    a_edge |=> o_aux_ld_tick)
    else $error("aux lock-detect tick missed");

  aux_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
    st_reg.ctl[1] |=> o_aux_cnt_rst && o_aux_cp_hiz)
    else $error("aux reset bit not applied");

  main_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
    st_reg.ctl[2] |=> o_main_cnt_rst && o_main_cp_hiz)
    else $error("main reset bit not applied");

  pwrup_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
    pwr_up |=> (o_main_cnt_rst && o_aux_cnt_rst) [*2])
    else $error("power-up counter reset missing");

  main_hiz_a: assert property (@(posedge i_clk) disable iff (i_rst)
    st_reg.ctl[3] && !st_reg.ctl[2] && st_reg.por == 4'h0 && !pwr_up
    |=> o_main_cp_hiz && !o_main_cnt_rst)
    else $error("main tri-state wrong");

  aux_hiz_a: assert property (@(posedge i_clk) disable iff (i_rst)
    st_reg.ctl[4] && !st_reg.ctl[1] && st_reg.por == 4'h0 && !pwr_up
    |=> o_aux_cp_hiz && !o_aux_cnt_rst)
    else $error("aux tri-state wrong");

  pump_drive_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !st_reg.ctl[2] && !st_reg.ctl[3] |=> !o_main_cp_hiz)
    else $error("main pump floats without cause");

  aux_drive_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !st_reg.ctl[1] && !st_reg.ctl[4] |=> !o_aux_cp_hiz)
    else $error("aux pump floats without cause");

  cnt_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !st_reg.ctl[2] && st_reg.por == 4'h0 && !pwr_up |=> !o_main_cnt_rst)
    else $error("main counters held without cause");

  ld_direct_a: assert property (@(posedge i_clk) disable iff (i_rst)
    m_edge && !st_reg.ctl[0] |=> o_main_ld_tick)
    else $error("undivided main lock-detect tick missed");

  ld_fourth_a: assert property (@(posedge i_clk) disable iff (i_rst)
    m_edge && st_reg.ctl[0] && st_reg.div == LD_DIV_LAST |=> o_main_ld_tick)
    else $error("fourth main lock-detect tick missed");

  ld_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !m_edge |=> !o_main_ld_tick)
    else $error("main lock-detect tick without edge");

endmodule

// ==== logic/plrtc_pkg.sv ====
// Constants for the PLL counter reset and tri-state control block
package plrtc_pkg;
  localparam int          WORD_W      = 24;
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  ADDR_SLIP   = 4'hD;
  localparam logic [3:0]  ADDR_CTRL   = 4'hF;
  localparam int          SLIP_MSB    = 23;
  localparam int          SLIP_LSB    = 22;
  localparam int          BIT_PRESC   = 4;
  localparam int          BIT_AUX_RST = 5;
  localparam int          BIT_MAIN_RST = 6;
  localparam int          BIT_MAIN_HIZ = 7;
  localparam int          BIT_AUX_HIZ = 8;
  localparam logic [1:0]  SLIP_RST    = 2'h0;
  localparam logic [4:0]  CTRL_RST    = 5'h00;
  localparam logic [2:0]  SHIFT_OFF   = 3'h0;
  localparam logic [2:0]  SHIFT_HALF  = 3'h1;
  localparam logic [2:0]  SHIFT_QUART = 3'h2;
  localparam logic [2:0]  SHIFT_SIXT  = 3'h4;
  localparam logic [1:0]  LD_DIV_LAST = 2'h3;
  localparam int          PWRUP_CYC   = 8;
endpackage

// ==== test/plrtc_ctrl_test.sv ====
// Self-checking bench for the serial control decode
`timescale 1ns/100ps
module plrtc_ctrl_test;
  import plrtc_pkg::*;
  localparam int PW = 2;
  logic       i_clk, i_rst, i_chip_en, i_sw_pwr_up, i_main_cmp, i_aux_cmp;
  logic       sck, sdat, sle, o_slip_en, o_mtick, o_atick;
  logic       o_mrst, o_arst, o_mhiz, o_ahiz;
  logic [2:0] o_slip_shift;
  logic [7:0] exp8;
  int         miscompares = 0, n_tests = 0, cyc = 0, n_main, n_aux;
  plrtc_host_model u_plrtc_host_model (.i_clk(i_clk), .o_ser_clk(sck),
    .o_ser_data(sdat), .o_ser_latch(sle));
  plrtc_ctrl #(.PWRUP_CYCLES(PW)) u_plrtc_ctrl (.i_clk(i_clk),
    .i_rst(i_rst), .i_ser_clk(sck), .i_ser_data(sdat), .i_ser_latch(sle),
    .i_chip_en(i_chip_en), .i_sw_pwr_up(i_sw_pwr_up),
    .i_main_cmp(i_main_cmp), .i_aux_cmp(i_aux_cmp),
    .o_slip_en(o_slip_en), .o_slip_shift(o_slip_shift),
    .o_main_cnt_rst(o_mrst),
    .o_aux_cnt_rst(o_arst), .o_main_cp_hiz(o_mhiz), .o_aux_cp_hiz(o_ahiz),
    .o_main_ld_tick(o_mtick), .o_aux_ld_tick(o_atick));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask
  task automatic wr(input logic [23:0] w);
    u_plrtc_host_model.write_word(w);
  endtask
  // Eight edges on both comparison clocks, ticks counted
  task automatic pulse_cmp();
    n_main = 0;
    n_aux = 0;
    repeat (8) begin
      {i_main_cmp, i_aux_cmp} = 2'h3;
      clks(4);
      {i_main_cmp, i_aux_cmp} = 2'h0;
      clks(4);
    end
    clks(6);
  endtask
  function automatic logic [7:0] pins();
    return {4'h0, o_mrst, o_arst, o_mhiz, o_ahiz};
  endfunction
  always @(posedge i_clk) begin
    cyc++;
    if (o_mtick === 1'b1) n_main++;
    if (o_atick === 1'b1) n_aux++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  initial begin
    {i_rst, i_chip_en, i_sw_pwr_up, i_main_cmp, i_aux_cmp} = 5'h10;
    clks(12);
    check(pins(), 8'h0C);
    i_rst = 1'b0;
    clks(PW + 4);
    check(pins(), 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr({s[1:0], 18'h0, 4'hD});
      exp8 = (s == 3) ? 8'h0C : {4'h0, s != 0, s[2:0]};
      check({o_slip_en, o_slip_shift}, exp8);
    end
    for (int v = 0; v < 32; v++) begin
      wr({15'h0, v[4:0], 4'hF});
      exp8 = {4'h0, v[2], v[1], v[2] | v[3], v[1] | v[4]};
      check(pins(), exp8);
    end
    wr(24'h00000E);
    check(pins(), 8'h0F);
    wr(24'h00000F);
    check(pins(), 8'h00);
    wr(24'h00001F);
    pulse_cmp();
    check(n_main[7:0], 8'h02);
    check(n_aux[7:0], 8'h08);
    wr(24'h00000F);
    pulse_cmp();
    check(n_main[7:0], 8'h08);
    i_sw_pwr_up = 1'b1;
    clks(1);
    i_sw_pwr_up = 1'b0;
    check(pins(), 8'h0C);
    clks(PW + 3);
    check(pins(), 8'h00);
    i_chip_en = 1'b1;
    clks(5);
    check(pins(), 8'h0C);
    clks(PW + 8);
    check(pins(), 8'h00);
    // Mid-run reset must restore all control defaults
    wr(24'h0001FF);
    check(pins(), 8'h0F);
    i_rst = 1'b1;
    clks(2);
    check(pins(), 8'h0C);
    i_rst = 1'b0;
    clks(PW + 8);
    check(pins(), 8'h00);
    check({o_slip_en, o_slip_shift}, 8'h00);
    print_verdict();
  end
endmodule

// ==== test/plrtc_host_model.sv ====
// Host model that writes words over the three-wire serial port
`timescale 1ns/100ps
module plrtc_host_model (
  input  wire logic i_clk,       // Bench clock
  output logic      o_ser_clk,   // Serial clock
  output logic      o_ser_data,  // Serial data
  output logic      o_ser_latch  // Latch enable
);
  initial begin
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
    o_ser_latch = 1'b0;
  end
  // Four clocks per phase, above the sync minimum
  task automatic hold4();
    repeat (4) @(posedge i_clk);
    #2;
  endtask
  task automatic write_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      o_ser_data = w[i];
      hold4();
      o_ser_clk = 1'b1;
      hold4();
      o_ser_clk = 1'b0;
    end
    // Data no longer valid, show the inverse
    o_ser_data = ~w[0];
    o_ser_latch = 1'b1;
    hold4();
    o_ser_latch = 1'b0;
    hold4();
  endtask
endmodule
